// >>> core/trc_top.sv
// Trigger source, first trigger delay and readout sequencer with AXI4-Lite registers.
// Assumes a measurement engine that takes a start pulse and returns a done pulse with data.
// Summary of operation
// - Trigger source internal or external, readable back
// - External mode: pin, common command, manual key; the command write is held off while a read waits, so only pin and key trigger
// - First trigger delay limited 0 to 0.100 s
// - External edge selectable rising or falling
// - Positive sign sent as space 20H
// - Fetch returns last value, no trigger
// - Read arms wait, answers after measurement
// - Internal source: read triggers at once
// - External source: read waits for edge
// - Read with continuous on is execution error
// - Read during trigger wait is held off until the value is out, then runs with no error
// - Read holds off later commands until done
// - Binary format sends value in binary
// - Triggers in idle state are ignored
// - After measurement: idle, or wait if continuous
//
// Design decisions made here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module trc_top
   import trc_pkg::*;
#(
   parameter int VAL_W = 32
) (
   input  wire logic             sys_clk_in,
   input  wire logic             rst_b_in,
   input  wire logic [7:0]       s_axi_awaddr,
   input  wire logic             s_axi_awvalid,
   output logic                  s_axi_awready,
   input  wire logic [31:0]      s_axi_wdata,
   input  wire logic [3:0]       s_axi_wstrb,
   input  wire logic             s_axi_wvalid,
   output logic                  s_axi_wready,
   output logic [1:0]            s_axi_bresp,
   output logic                  s_axi_bvalid,
   input  wire logic             s_axi_bready,
   input  wire logic [7:0]       s_axi_araddr,
   input  wire logic             s_axi_arvalid,
   output logic                  s_axi_arready,
   output logic [31:0]           s_axi_rdata,
   output logic [1:0]            s_axi_rresp,
   output logic                  s_axi_rvalid,
   input  wire logic             s_axi_rready,
   input  wire logic             external_trigger_input_in,
   input  wire logic             manual_trigger_key_in,
   output logic                  meas_start_out,
   input  wire logic             meas_done_in,
   input  wire logic             meas_neg_in,
   input  wire logic [VAL_W-1:0] meas_value_in,
   output logic                  value_valid_out,
   output logic [7:0]            value_sign_out,
   output logic                  value_binary_out,
   output logic [VAL_W-1:0]      value_data_out
);
   logic             external_trigger_input_ext_ff, edge_fall_ff, cont_ff, binary_ff;
   logic [16:0]      delay_us_ff;
   trc_state_t       state_ff, nxt_state;
   logic [16:0]      dly_cnt_ff;
   logic [7:0]       us_cnt_ff;
   logic             pin_s1_ff, pin_s2_ff, pin_s3_ff;
   logic             read_pend_ff, exe_err_ff, have_val_ff;
   logic [VAL_W-1:0] last_val_ff;
   logic             last_neg_ff;
   logic             aw_got_ff, w_got_ff;
   logic [7:0]       aw_addr_ff;
   logic [31:0]      w_data_ff;
   logic [3:0]       w_strb_ff;

   // Write side: address and data are latched independently, then applied once.
   wire wr_fire   = aw_got_ff && w_got_ff && !s_axi_bvalid;
   wire wr_ok     = (aw_addr_ff <= ADDR_COMMAND) && (aw_addr_ff[1:0] == 2'h0);
   wire wr_lo     = w_strb_ff[0];
   wire wr_cmd    = wr_fire && wr_lo && aw_addr_ff == ADDR_COMMAND;
   wire cmd_fetch = wr_cmd && w_data_ff[CMD_FETCH_BIT];
   wire cmd_read  = wr_cmd && w_data_ff[CMD_READ_BIT];
   wire cmd_swtrg = wr_cmd && w_data_ff[CMD_SWTRIG_BIT];
   wire cmd_eclr  = wr_cmd && w_data_ff[CMD_ERRCLR_BIT];
   // A pending read stalls further writes until its value is out.
   wire hold_off  = read_pend_ff;
   assign s_axi_awready = !aw_got_ff && !hold_off;
   assign s_axi_wready  = !w_got_ff && !hold_off;

   // Trigger pin synchroniser and selected-edge detector.
   wire pin_rise   = pin_s2_ff && !pin_s3_ff;
   wire pin_fall   = !pin_s2_ff && pin_s3_ff;
   wire pin_edge   = edge_fall_ff ? pin_fall : pin_rise;
   wire ext_external_trigger_input   = pin_edge || cmd_swtrg || manual_trigger_key_in;
   wire external_trigger_input_now   = external_trigger_input_ext_ff ? ext_external_trigger_input : 1'b1;
   // Read is refused when continuous or already waiting.
   wire read_bad   = cmd_read && (cont_ff || state_ff != ST_IDLE);
   wire read_go    = cmd_read && !read_bad;
   wire us_tick    = us_cnt_ff == 8'(US_CYCLES - 1);
   wire dly_done   = dly_cnt_ff == 17'h00000;
   wire meas_end   = state_ff == ST_MEAS && meas_done_in;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (read_go) begin
               nxt_state = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (external_trigger_input_now) begin
               nxt_state = ST_DELAY;
            end
         end
         ST_DELAY: begin
            if (dly_done) begin
               nxt_state = ST_MEAS;
            end
         end
         ST_MEAS: begin
            if (meas_done_in) begin
               nxt_state = cont_ff ? ST_WAIT : ST_IDLE;
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   assign meas_start_out = state_ff == ST_DELAY && dly_done;

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_ff   <= ST_IDLE;
         dly_cnt_ff <= 17'h00000;
         us_cnt_ff  <= 8'h00;
         pin_s1_ff  <= 1'b0;
         pin_s2_ff  <= 1'b0;
         pin_s3_ff  <= 1'b0;
      end else begin
         state_ff  <= nxt_state;
         pin_s1_ff <= external_trigger_input_in;
         pin_s2_ff <= pin_s1_ff;
         pin_s3_ff <= pin_s2_ff;
         if (state_ff == ST_WAIT) begin
            dly_cnt_ff <= delay_us_ff;
            us_cnt_ff  <= 8'h00;
         end else if (state_ff == ST_DELAY && !dly_done) begin
            us_cnt_ff <= us_tick ? 8'h00 : us_cnt_ff + 8'h01;
            if (us_tick) begin
               dly_cnt_ff <= dly_cnt_ff - 17'h00001;
            end
         end
      end
   end

   // Settings registers; the delay saturates at its limit.
   wire [16:0] wr_delay = (w_data_ff[31:17] != 15'h0000 || w_data_ff[16:0] > DELAY_MAX_US)
                        ? DELAY_MAX_US : w_data_ff[16:0];
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         external_trigger_input_ext_ff  <= RST_EXTERNAL_TRIGGER_INPUT_EXT;
         edge_fall_ff <= RST_EDGE_FALL;
         cont_ff      <= RST_CONT;
         binary_ff    <= RST_BINARY;
         delay_us_ff  <= RST_DELAY_MS;
      end else if (wr_fire && wr_lo) begin
         if (aw_addr_ff == ADDR_EXTERNAL_TRIGGER_INPUT_SRC) begin
            external_trigger_input_ext_ff <= w_data_ff[0];
         end
         if (aw_addr_ff == ADDR_DELAY) begin
            delay_us_ff <= wr_delay;
         end
         if (aw_addr_ff == ADDR_EDGE) begin
            edge_fall_ff <= w_data_ff[0];
         end
         if (aw_addr_ff == ADDR_CONTROL) begin
            cont_ff   <= w_data_ff[CTL_CONT_BIT];
            binary_ff <= w_data_ff[CTL_BINARY_BIT];
         end
      end
   end

   // Readout: fetch sends the stored value, a read sends the next one.
   wire send_now = cmd_fetch || (read_pend_ff && meas_end);
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         read_pend_ff     <= 1'b0;
         exe_err_ff       <= 1'b0;
         have_val_ff      <= 1'b0;
         last_val_ff      <= '0;
         last_neg_ff      <= 1'b0;
         value_valid_out  <= 1'b0;
         value_sign_out   <= CHAR_SPACE;
         value_binary_out <= 1'b0;
         value_data_out   <= '0;
      end else begin
         if (read_go) begin
            read_pend_ff <= 1'b1;
         end else if (meas_end) begin
            read_pend_ff <= 1'b0;
         end
         // A new error in the clearing cycle wins over the clear.
         if (read_bad) begin
            exe_err_ff <= 1'b1;
         end else if (cmd_eclr) begin
            exe_err_ff <= 1'b0;
         end
         if (meas_end) begin
            have_val_ff <= 1'b1;
            last_val_ff <= meas_value_in;
            last_neg_ff <= meas_neg_in;
         end
         value_valid_out <= send_now;
         if (send_now) begin
            value_binary_out <= binary_ff;
            value_data_out   <= (read_pend_ff && meas_end) ? meas_value_in : last_val_ff;
            if ((read_pend_ff && meas_end) ? meas_neg_in : last_neg_ff) begin
               value_sign_out <= CHAR_MINUS;
            end else begin
               value_sign_out <= CHAR_SPACE;
            end
         end
      end
   end

   // Read-side mux; unmapped addresses answer SLVERR with zero data.
   wire [31:0] status_word = {26'h0000000, have_val_ff, exe_err_ff, read_pend_ff,
                              state_ff == ST_MEAS, state_ff == ST_DELAY,
                              state_ff == ST_WAIT};
   wire rd_ok = (s_axi_araddr <= ADDR_RESULT_HI) && (s_axi_araddr[1:0] == 2'h0);
   logic [31:0] rd_word;
   always_comb begin
      case (s_axi_araddr)
         ADDR_EXTERNAL_TRIGGER_INPUT_SRC:  rd_word = {31'h00000000, external_trigger_input_ext_ff};
         ADDR_DELAY:     rd_word = {15'h0000, delay_us_ff};
         ADDR_EDGE:      rd_word = {31'h00000000, edge_fall_ff};
         ADDR_CONTROL:   rd_word = {30'h00000000, binary_ff, cont_ff};
         ADDR_STATUS:    rd_word = status_word;
         ADDR_RESULT:    rd_word = 32'(last_val_ff);
         ADDR_RESULT_HI: rd_word = {23'h000000, last_neg_ff, last_neg_ff ? CHAR_MINUS : CHAR_SPACE};
         default:        rd_word = 32'h00000000;
      endcase
   end
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         aw_got_ff    <= 1'b0;
         w_got_ff     <= 1'b0;
         aw_addr_ff   <= 8'h00;
         w_data_ff    <= 32'h00000000;
         w_strb_ff    <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= RESP_OKAY;
         s_axi_rdata  <= 32'h00000000;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_ff  <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_ff  <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_got_ff    <= 1'b0;
            w_got_ff     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : trc_top
`default_nettype wire

// >>> shared/trc_pkg.sv
// Package for the trigger and readout control block.
// Holds register offsets, field positions, reset values and timing constants.
package trc_pkg;
   // Register byte offsets on the AXI4-Lite slave.
   localparam logic [7:0] ADDR_EXTERNAL_TRIGGER_INPUT_SRC  = 8'h00;
   localparam logic [7:0] ADDR_DELAY     = 8'h04;
   localparam logic [7:0] ADDR_EDGE      = 8'h08;
   localparam logic [7:0] ADDR_CONTROL   = 8'h0C;
   localparam logic [7:0] ADDR_COMMAND   = 8'h10;
   localparam logic [7:0] ADDR_STATUS    = 8'h14;
   localparam logic [7:0] ADDR_RESULT    = 8'h18;
   localparam logic [7:0] ADDR_RESULT_HI = 8'h1C;
   // Command register bits, write-one pulses.
   localparam int CMD_FETCH_BIT  = 0;
   localparam int CMD_READ_BIT   = 1;
   localparam int CMD_SWTRIG_BIT = 2;
   localparam int CMD_ERRCLR_BIT = 3;
   // Control register bits.
   localparam int CTL_CONT_BIT   = 0;
   localparam int CTL_BINARY_BIT = 1;
   // Status register bits.
   localparam int STS_WAIT_BIT   = 0;
   localparam int STS_DELAY_BIT  = 1;
   localparam int STS_MEAS_BIT   = 2;
   localparam int STS_BUSY_BIT   = 3;
   localparam int STS_EXEERR_BIT = 4;
   localparam int STS_VALID_BIT  = 5;
   // Reset values.
   localparam logic        RST_EXTERNAL_TRIGGER_INPUT_EXT   = 1'b0;
   localparam logic        RST_EDGE_FALL  = 1'b0;
   localparam logic        RST_CONT       = 1'b0;
   localparam logic        RST_BINARY     = 1'b0;
   localparam logic [16:0] RST_DELAY_MS   = 17'h00000;
   // Delay in units of one microsecond; 0.100 s upper limit.
   localparam int          DELAY_UNIT_NS  = 1000;
   localparam logic [16:0] DELAY_MAX_US   = 17'h186A0;
   localparam int          CLK_PERIOD_NS  = 4;
   localparam int          US_CYCLES      = DELAY_UNIT_NS / CLK_PERIOD_NS;
   // Text sign characters.
   localparam logic [7:0]  CHAR_SPACE     = 8'h20;
   localparam logic [7:0]  CHAR_MINUS     = 8'h2D;
   localparam logic [7:0]  CHAR_PLUS      = 8'h2B;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_WAIT  = 3'b001,
      ST_DELAY = 3'b010,
      ST_MEAS  = 3'b011
   } trc_state_t;
endpackage : trc_pkg

// >>> tb/trc_meas_model.sv
// Measurement engine model for the trigger and readout control bench.
// Answers each start pulse after lat_in plus two cycles; lines churn while idle.
`timescale 1ns/1ps
`default_nettype none
module trc_meas_model (
   input  wire logic        clk_in,
   input  wire logic        start_in,
   input  wire logic [3:0]  lat_in,
   input  wire logic [31:0] val_in,
   input  wire logic        neg_in,
   output logic             done_out,
   output logic [31:0]      value_out,
   output logic             neg_out
);
   logic [4:0] cnt_ff = 5'h00;
   initial {done_out, value_out, neg_out} = '0;
   // Outside the done cycle the data toggles, so a stale capture cannot pass.
   always @(posedge clk_in) begin
      done_out  <= cnt_ff == 5'h01;
      value_out <= (cnt_ff == 5'h01) ? val_in : ~value_out;
      neg_out   <= (cnt_ff == 5'h01) ? neg_in : ~neg_out;
      if (start_in) cnt_ff <= {1'b0, lat_in} + 5'h01;
      else if (cnt_ff != 5'h00) cnt_ff <= cnt_ff - 5'h01;
   end
endmodule : trc_meas_model
`default_nettype wire

// >>> tb/trc_chk_sva.sv
// Port checker for the trigger and readout control block.
// Sees the top module's ports only and is bound to it below.
`timescale 1ns/1ps
`default_nettype none
module trc_chk
   import trc_pkg::*;
#(
   parameter int VAL_W = 32
) (
   input wire logic             sys_clk_in,
   input wire logic             rst_b_in,
   input wire logic             s_axi_awready,
   input wire logic             s_axi_wready,
   input wire logic             s_axi_rvalid,
   input wire logic             s_axi_rready,
   input wire logic             meas_start_out,
   input wire logic             meas_done_in,
   input wire logic             meas_neg_in,
   input wire logic [VAL_W-1:0] meas_value_in,
   input wire logic             value_valid_out,
   input wire logic [7:0]       value_sign_out,
   input wire logic [VAL_W-1:0] value_data_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);
   sequence s_send;
      ##1 value_valid_out && value_data_out == $past(meas_value_in);
   endsequence
   // The sign may only change on the edge that raises value valid.
   sequence s_quiet;
      !value_valid_out ##1 !value_valid_out;
   endsequence
   chk_done_send: assert property (meas_done_in |-> s_send)
      else $error("value not sent after done");
   chk_sign_pos: assert property (meas_done_in && !meas_neg_in |=> value_sign_out == 8'h20)
      else $error("positive sign not a space");
   chk_sign_neg: assert property (meas_done_in && meas_neg_in |=> value_sign_out == 8'h2D)
      else $error("negative sign wrong");
   chk_valid_pulse: assert property (value_valid_out |=> !value_valid_out)
      else $error("value valid longer than one cycle");
   chk_start_pulse: assert property (meas_start_out |=> !meas_start_out)
      else $error("start longer than one cycle");
   chk_hold_off: assert property (meas_start_out || meas_done_in |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted during measurement");
   chk_sign_hold: assert property (s_quiet |-> $stable(value_sign_out))
      else $error("sign changed without a send");
   chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read answer dropped early");
endmodule : trc_chk
bind trc_top trc_chk #(.VAL_W(VAL_W)) trc_chk_inst (.sys_clk_in, .rst_b_in, .s_axi_awready,
   .s_axi_wready, .s_axi_rvalid, .s_axi_rready, .meas_start_out, .meas_done_in, .meas_neg_in,
   .meas_value_in, .value_valid_out, .value_sign_out, .value_data_out);
`default_nettype wire

// >>> tb/trc_top_tb.sv
// Self-checking bench for the trigger and readout control block.
// Drives the register bus, trigger pin and key; a model stands for the engine.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
   $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module trc_top_tb;
   import trc_pkg::*;
   logic        sys_clk_in, rst_b_in, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, external_trigger_input_in, manual_trigger_key_in, meas_start_out;
   logic        meas_done_in, meas_neg_in, value_valid_out, value_binary_out, mneg;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
   logic [3:0]  s_axi_wstrb, lat;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, value_sign_out;
   logic [31:0] s_axi_wdata, s_axi_rdata, meas_value_in, value_data_out, mval, rd;
   logic [15:0] seed;
   logic [40:0] note, popped;
   logic [40:0] exp_q[$];
   int          num_errors, samples_checked, n_start, cyc, st_cyc, c0, c1;
   trc_top #(.VAL_W(32)) trc_top_inst (.*);
   trc_meas_model trc_meas_model_inst (.clk_in(sys_clk_in), .start_in(meas_start_out),
      .lat_in(lat), .val_in(mval), .neg_in(mneg), .done_out(meas_done_in),
      .value_out(meas_value_in), .neg_out(meas_neg_in));
   initial begin
      sys_clk_in = 1'b0;
      forever #2 sys_clk_in = ~sys_clk_in;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   task automatic give_verdict();
      $display("checked=%0d errors=%0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_in);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge sys_clk_in);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rr = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a);
      @(posedge sys_clk_in);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(posedge sys_clk_in);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axi_rd
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      axi_rd(a);
      `CHK(rd, e)
   endtask : rd_chk
   task automatic rd_cmd(input logic neg, input logic bin);
      seed = lfsr(seed);
      mval <= {seed, ~seed};
      mneg <= neg;
      note = {bin, (neg ? 8'h2D : 8'h20), seed, ~seed};
      exp_q.push_back(note);
      c0 = n_start;
      axi_wr(ADDR_COMMAND, 32'h2);
      c1 = cyc;
   endtask : rd_cmd
   task automatic wait_q();
      for (int i = 0; i < 3000 && exp_q.size() != 0; i++) @(posedge sys_clk_in);
      `CHK(exp_q.size(), 0)
   endtask : wait_q
   task automatic drive_in(input logic pin, input logic key);
      @(posedge sys_clk_in);
      {external_trigger_input_in, manual_trigger_key_in} <= {pin, key};
      @(posedge sys_clk_in);
      manual_trigger_key_in <= 1'b0;
      repeat (20) @(posedge sys_clk_in);
   endtask : drive_in
   always @(posedge sys_clk_in) begin
      cyc++;
      if (meas_start_out === 1'b1) begin
         n_start++;
         st_cyc = cyc;
      end
      if (value_valid_out === 1'b1) begin
         popped = exp_q.size() != 0 ? exp_q.pop_front() : 41'h0;
         `CHK(({value_binary_out, value_sign_out, value_data_out}), popped)
      end
   end
   initial begin
      #200000;
      num_errors++;
      give_verdict();
   end
   initial begin
      {rst_b_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {external_trigger_input_in, manual_trigger_key_in, mneg, s_axi_awaddr, s_axi_araddr} = '0;
      {s_axi_wdata, mval, lat} = '0;
      s_axi_wstrb = 4'hF;
      seed = 16'h6189;
      repeat (3) @(posedge sys_clk_in);
      rst_b_in <= 1'b1;
      rd_chk(ADDR_EXTERNAL_TRIGGER_INPUT_SRC, 32'h0);
      rd_chk(ADDR_EDGE, 32'h0);
      axi_rd(8'h24);
      `CHK(rr, RESP_SLVERR)
      axi_wr(8'h24, 32'h0);
      `CHK(rr, RESP_SLVERR)
      axi_wr(ADDR_DELAY, 32'h186A5);
      `CHK(rr, RESP_OKAY)
      rd_chk(ADDR_DELAY, 32'h186A0);
      axi_wr(ADDR_DELAY, 32'h2);
      rd_chk(ADDR_DELAY, 32'h2);
      $display("test registers done");
      rd_cmd(1'b0, 1'b0);
      axi_wr(ADDR_EDGE, 32'h0);
      `CHK(n_start, c0 + 1)
      `CHK(((st_cyc - c1 - 2 * US_CYCLES) inside {[0:8]}), 1'b1)
      wait_q();
      axi_wr(ADDR_CONTROL, 32'h2);
      exp_q.push_back({1'b1, note[39:0]});
      axi_wr(ADDR_COMMAND, 32'h1);
      wait_q();
      `CHK(n_start, c0 + 1)
      lat <= 4'h9;
      rd_cmd(1'b1, 1'b1);
      wait_q();
      axi_wr(ADDR_CONTROL, 32'h1);
      axi_wr(ADDR_COMMAND, 32'h2);
      rd_chk(ADDR_STATUS, 32'h30);
      axi_wr(ADDR_COMMAND, 32'h8);
      axi_wr(ADDR_CONTROL, 32'h0);
      rd_chk(ADDR_STATUS, 32'h20);
      $display("test internal done");
      // Values are taken only through read commands, never also auto-sent.
      axi_wr(ADDR_EXTERNAL_TRIGGER_INPUT_SRC, 32'h1);
      rd_chk(ADDR_EXTERNAL_TRIGGER_INPUT_SRC, 32'h1);
      axi_wr(ADDR_DELAY, 32'h0);
      drive_in(1'b0, 1'b1);
      `CHK(n_start, c0 + 1)
      rd_cmd(1'b0, 1'b0);
      rd_chk(ADDR_STATUS, 32'h29);
      drive_in(1'b1, 1'b0);
      wait_q();
      rd_cmd(1'b1, 1'b0);
      drive_in(1'b1, 1'b1);
      wait_q();
      axi_wr(ADDR_EDGE, 32'h1);
      rd_cmd(1'b0, 1'b0);
      drive_in(1'b0, 1'b0);
      wait_q();
      rd_cmd(1'b0, 1'b0);
      drive_in(1'b1, 1'b0);
      `CHK(n_start, c0)
      drive_in(1'b0, 1'b0);
      wait_q();
      $display("test external done");
      give_verdict();
   end
endmodule : trc_top_tb
`default_nettype wire
